// *** fdc_regs.sv ***
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - nine 8-bit output duty entries at 0x00-0x08, defaults 0x1f up to 0xff
// - bits 7:6 of 0x09 count memory commits: 00 none, 01 once, 10 twice
// - bits 7:6 of 0x0a pick indicator: tach, half tach, or lock
// - bits 5:3 of 0x0a set minimum speed resolution, default 011
// - bit 2 of 0x0a picks soft-start ramp time, 1 gives 5.2s
// - bits 1:0 of 0x0a select high-side current limit, default 10
// - bit 7 of 0x0b reads back the live tach level
// - bit 6 of 0x0b reads 1 in test mode; memory block inactive there
// - bit 5 of 0x0b enables zero speed below starting duty, default 1
// - bit 6 of 0x0d enables soft phase switching, default 1
// - bit 5 of 0x0d sets lock indication polarity, 0 means high when locked
// - bit 6 of 0x0f enables current zero-crossing phase lock, default 1
// - bits 5:4 of 0x0f select lock retry wait, default 11
// - 0x14 holds starting duty threshold, linear 0 to 100%, default 0x20
// - zero speed below threshold; restart only above threshold plus hysteresis
// - without zero speed, below threshold output holds the first table entry
// - memory commits allowed at most twice

module fdc_regs (
    input wire logic clk,
    input wire logic rst,
    input wire fdc_pkg::fdc_axi_req_t axi_req,
    output fdc_pkg::fdc_axi_rsp_t axi_rsp,
    input wire logic [7:0] duty_in,
    input wire logic tach_in,
    input wire logic lock_in,
    input wire logic test_in,
    output logic [7:0] duty_out,
    output fdc_pkg::fdc_cfg_t cfg_out,
    output logic ind_o,
    output logic ind_oe_n,
    output logic nvm_otp_program_count_o
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [8:0][7:0] lut;
        logic [1:0] otp_program_count_cnt;
        logic [1:0] ind_sel;
        logic [2:0] min_spd;
        logic ramp_sel;
        logic [1:0] ilim;
        logic zero_en;
        logic soft_en;
        logic lock_pol;
        logic pll_en;
        logic [1:0] retry_sel;
        logic fact_mode;
        logic [7:0] thr;
        logic tach_s1;
        logic tach_s2;
        logic tach_s3;
        logic test_s1;
        logic test_s2;
        logic lock_s1;
        logic lock_s2;
        logic tach_half;
        logic running;
        logic [7:0] duty;
        logic ind_oe_n;
        logic ind_dat;
        logic nvm_pulse;
        logic awrdy;
        logic wrdy;
        logic [5:0] widx;
        logic [7:0] wdat;
        logic wen;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } fdc_state_t;

    fdc_state_t s_r;
    fdc_state_t s_nxt;

    // ********************************
    // helpers
    // ********************************
    function automatic logic is_mapped(input logic [5:0] idx);
        logic m;
        m = (idx <= fdc_pkg::IDX_LUT_LAST);
        case (idx)
            fdc_pkg::IDX_OTP_PROGRAM_COUNT, fdc_pkg::IDX_CFG, fdc_pkg::IDX_STAT,
            fdc_pkg::IDX_SOFT, fdc_pkg::IDX_PLL, fdc_pkg::IDX_FACT,
            fdc_pkg::IDX_THR, fdc_pkg::IDX_COMMIT: m = 1'b1;
            default: ;
        endcase
        return m;
    endfunction : is_mapped

    function automatic logic [7:0] rd_reg(input fdc_state_t s, input logic [5:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx <= fdc_pkg::IDX_LUT_LAST) begin
            v = s.lut[idx[3:0]];
        end else begin
            case (idx)
                fdc_pkg::IDX_OTP_PROGRAM_COUNT: v[fdc_pkg::POS_OTP_PROGRAM_COUNT +: 2] = s.otp_program_count_cnt;
                fdc_pkg::IDX_CFG: begin
                    v[fdc_pkg::POS_IND_SEL +: 2] = s.ind_sel;
                    v[fdc_pkg::POS_MIN_SPD +: 3] = s.min_spd;
                    v[fdc_pkg::POS_RAMP] = s.ramp_sel;
                    v[fdc_pkg::POS_ILIM +: 2] = s.ilim;
                end
                fdc_pkg::IDX_STAT: begin
                    v[fdc_pkg::POS_TACH] = s.tach_s2;
                    v[fdc_pkg::POS_TEST] = s.test_s2;
                    v[fdc_pkg::POS_ZERO] = s.zero_en;
                end
                fdc_pkg::IDX_SOFT: begin
                    v[fdc_pkg::POS_SOFT] = s.soft_en;
                    v[fdc_pkg::POS_LPOL] = s.lock_pol;
                end
                fdc_pkg::IDX_PLL: begin
                    v[fdc_pkg::POS_PLL] = s.pll_en;
                    v[fdc_pkg::POS_RETRY +: 2] = s.retry_sel;
                end
                fdc_pkg::IDX_FACT: v[fdc_pkg::POS_FACT] = s.fact_mode;
                fdc_pkg::IDX_THR: v = s.thr;
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction : rd_reg

    // linear blend between two neighbouring table entries
    function automatic logic [7:0] lut_blend(input logic [7:0] lo, input logic [7:0] hi,
                                              input logic [4:0] frac);
        logic signed [8:0] diff;
        logic signed [14:0] prod;
        logic signed [9:0] sum;
        diff = $signed({1'b0, hi}) - $signed({1'b0, lo});
        prod = 15'(diff * $signed({1'b0, frac}));
        sum = $signed({2'b00, lo}) + 10'(prod >>> 5);
        return sum[7:0];
    endfunction : lut_blend

    // ********************************
    // next state
    // ********************************
    logic [8:0] thr_hi;
    logic [3:0] seg;
    logic ind_level;

    always_comb begin
        s_nxt = s_r;
        thr_hi = {1'b0, s_r.thr} + fdc_pkg::HYST_STEPS;
        seg = {1'b0, duty_in[7:5]};
        ind_level = s_r.tach_s2;

        // pin synchronisers; stage two is read, and tach stage three also feeds the edge detect
        s_nxt.tach_s1 = tach_in;
        s_nxt.tach_s2 = s_r.tach_s1;
        s_nxt.tach_s3 = s_r.tach_s2;
        s_nxt.test_s1 = test_in;
        s_nxt.test_s2 = s_r.test_s1;
        s_nxt.lock_s1 = lock_in;
        s_nxt.lock_s2 = s_r.lock_s1;
        s_nxt.nvm_pulse = 1'b0;

        // half-rate tach toggles on each rising edge
        if (s_r.tach_s2 && !s_r.tach_s3) begin
            s_nxt.tach_half = !s_r.tach_half;
        end

        // indicator select; reserved code falls back to plain tach
        case (fdc_pkg::fdc_ind_sel_t'(s_r.ind_sel))
            fdc_pkg::IND_TACH: ind_level = s_r.tach_s2;
            fdc_pkg::IND_TACH_HALF: ind_level = s_r.tach_half;
            fdc_pkg::IND_LOCK: ind_level = s_r.lock_s2 ^ s_r.lock_pol;
            default: ind_level = s_r.tach_s2;
        endcase
        // open drain: enable asserted (low) only to pull the line low
        s_nxt.ind_oe_n = ind_level;
        s_nxt.ind_dat = 1'b0;

        // start/stop with hysteresis so the fan does not chatter at the edge
        if (!s_r.zero_en) begin
            s_nxt.running = 1'b1;
        end else if (!s_r.running && ({1'b0, duty_in} > thr_hi)) begin
            s_nxt.running = 1'b1;
        end else if (s_r.running && (duty_in < s_r.thr)) begin
            s_nxt.running = 1'b0;
        end

        if (s_r.zero_en && !s_r.running) begin
            s_nxt.duty = 8'h00;
        end else if (duty_in < s_r.thr) begin
            s_nxt.duty = s_r.lut[0];
        end else begin
            s_nxt.duty = lut_blend(s_r.lut[seg], s_r.lut[seg + 4'h1], duty_in[4:0]);
        end

        // ********************************
        // write channel
        // ********************************
        if (axi_req.awvalid && s_r.awrdy) begin
            s_nxt.awrdy = 1'b0;
            s_nxt.widx = axi_req.awaddr[7:2];
        end
        if (axi_req.wvalid && s_r.wrdy) begin
            s_nxt.wrdy = 1'b0;
            s_nxt.wdat = axi_req.wdata[7:0];
            s_nxt.wen = axi_req.wstrb[0];
        end
        if (!s_r.awrdy && !s_r.wrdy && !s_r.bvalid) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = is_mapped(s_r.widx) ? fdc_pkg::RESP_OKAY : fdc_pkg::RESP_SLVERR;
            if (s_r.wen) begin
                if (s_r.widx <= fdc_pkg::IDX_LUT_LAST) begin
                    s_nxt.lut[s_r.widx[3:0]] = s_r.wdat;
                end
                case (s_r.widx)
                    fdc_pkg::IDX_CFG: begin
                        s_nxt.ind_sel = s_r.wdat[fdc_pkg::POS_IND_SEL +: 2];
                        s_nxt.min_spd = s_r.wdat[fdc_pkg::POS_MIN_SPD +: 3];
                        s_nxt.ramp_sel = s_r.wdat[fdc_pkg::POS_RAMP];
                        s_nxt.ilim = s_r.wdat[fdc_pkg::POS_ILIM +: 2];
                    end
                    fdc_pkg::IDX_STAT: s_nxt.zero_en = s_r.wdat[fdc_pkg::POS_ZERO];
                    fdc_pkg::IDX_SOFT: begin
                        s_nxt.soft_en = s_r.wdat[fdc_pkg::POS_SOFT];
                        s_nxt.lock_pol = s_r.wdat[fdc_pkg::POS_LPOL];
                    end
                    fdc_pkg::IDX_PLL: begin
                        s_nxt.pll_en = s_r.wdat[fdc_pkg::POS_PLL];
                        s_nxt.retry_sel = s_r.wdat[fdc_pkg::POS_RETRY +: 2];
                    end
                    fdc_pkg::IDX_FACT: s_nxt.fact_mode = s_r.wdat[fdc_pkg::POS_FACT];
                    fdc_pkg::IDX_THR: s_nxt.thr = s_r.wdat;
                    fdc_pkg::IDX_COMMIT: begin
                        // memory block is dark in test mode, and the count saturates
                        if (s_r.wdat[fdc_pkg::POS_COMMIT] && s_r.fact_mode && !s_r.test_s2
                            && (s_r.otp_program_count_cnt < fdc_pkg::OTP_PROGRAM_COUNT_MAX)) begin
                            s_nxt.otp_program_count_cnt = s_r.otp_program_count_cnt + 2'h1;
                            s_nxt.nvm_pulse = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (s_r.bvalid && axi_req.bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awrdy = 1'b1;
            s_nxt.wrdy = 1'b1;
        end

        // ********************************
        // read channel
        // ********************************
        if (axi_req.arvalid && s_r.arrdy) begin
            s_nxt.arrdy = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = {24'h000000, rd_reg(s_r, axi_req.araddr[7:2])};
            s_nxt.rresp = is_mapped(axi_req.araddr[7:2]) ? fdc_pkg::RESP_OKAY
                                                         : fdc_pkg::RESP_SLVERR;
        end
        if (s_r.rvalid && axi_req.rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arrdy = 1'b1;
        end

        if (rst) begin
            s_nxt = '0;
            s_nxt.lut = fdc_pkg::RST_LUT;
            s_nxt.otp_program_count_cnt = fdc_pkg::RST_OTP_PROGRAM_COUNT;
            s_nxt.ind_sel = fdc_pkg::RST_IND_SEL;
            s_nxt.min_spd = fdc_pkg::RST_MIN_SPD;
            s_nxt.ramp_sel = fdc_pkg::RST_RAMP;
            s_nxt.ilim = fdc_pkg::RST_ILIM;
            s_nxt.zero_en = fdc_pkg::RST_ZERO;
            s_nxt.soft_en = fdc_pkg::RST_SOFT;
            s_nxt.lock_pol = fdc_pkg::RST_LPOL;
            s_nxt.pll_en = fdc_pkg::RST_PLL;
            s_nxt.retry_sel = fdc_pkg::RST_RETRY;
            s_nxt.fact_mode = fdc_pkg::RST_FACT;
            s_nxt.thr = fdc_pkg::RST_THR;
            s_nxt.ind_oe_n = 1'b1;
            s_nxt.awrdy = 1'b1;
            s_nxt.wrdy = 1'b1;
            s_nxt.arrdy = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    // ********************************
    // outputs
    // ********************************
    assign axi_rsp.awready = s_r.awrdy;
    assign axi_rsp.wready = s_r.wrdy;
    assign axi_rsp.bvalid = s_r.bvalid;
    assign axi_rsp.bresp = s_r.bresp;
    assign axi_rsp.arready = s_r.arrdy;
    assign axi_rsp.rvalid = s_r.rvalid;
    assign axi_rsp.rdata = s_r.rdata;
    assign axi_rsp.rresp = s_r.rresp;
    assign duty_out = s_r.duty;
    assign cfg_out.min_speed_resolution = s_r.min_spd;
    assign cfg_out.duty_ramp_time_sel = s_r.ramp_sel;
    assign cfg_out.current_limit_sel = s_r.ilim;
    assign cfg_out.soft_switching_enable = s_r.soft_en;
    assign cfg_out.phase_lock_enable = s_r.pll_en;
    assign cfg_out.lock_retry_time_sel = s_r.retry_sel;
    // open drain: data stays low, the enable does the signalling
    assign ind_o = s_r.ind_dat;
    assign ind_oe_n = s_r.ind_oe_n;
    assign nvm_otp_program_count_o = s_r.nvm_pulse;

endmodule : fdc_regs

// *** fdc_pkg.sv ***
package fdc_pkg;

    // ********************************
    // register indices (byte address = 4 * index)
    // ********************************
    localparam logic [5:0] IDX_LUT_LAST = 6'h08;
    localparam logic [5:0] IDX_OTP_PROGRAM_COUNT = 6'h09;
    localparam logic [5:0] IDX_CFG = 6'h0a;
    localparam logic [5:0] IDX_STAT = 6'h0b;
    localparam logic [5:0] IDX_SOFT = 6'h0d;
    localparam logic [5:0] IDX_PLL = 6'h0f;
    localparam logic [5:0] IDX_FACT = 6'h10;
    localparam logic [5:0] IDX_THR = 6'h14;
    localparam logic [5:0] IDX_COMMIT = 6'h15;

    // ********************************
    // field positions
    // ********************************
    localparam int POS_OTP_PROGRAM_COUNT = 6;
    localparam int POS_IND_SEL = 6;
    localparam int POS_MIN_SPD = 3;
    localparam int POS_RAMP = 2;
    localparam int POS_ILIM = 0;
    localparam int POS_TACH = 7;
    localparam int POS_TEST = 6;
    localparam int POS_ZERO = 5;
    localparam int POS_SOFT = 6;
    localparam int POS_LPOL = 5;
    localparam int POS_PLL = 6;
    localparam int POS_RETRY = 4;
    localparam int POS_FACT = 4;
    localparam int POS_COMMIT = 0;

    // ********************************
    // values after reset
    // ********************************
    localparam logic [8:0][7:0] RST_LUT = {
        8'hff, 8'hdf, 8'hbf, 8'h9f, 8'h7f, 8'h5f, 8'h3f, 8'h1f, 8'h1f};
    localparam logic [1:0] RST_OTP_PROGRAM_COUNT = 2'h0;
    localparam logic [1:0] RST_IND_SEL = 2'h0;
    localparam logic [2:0] RST_MIN_SPD = 3'h3;
    localparam logic RST_RAMP = 1'h1;
    localparam logic [1:0] RST_ILIM = 2'h2;
    localparam logic RST_ZERO = 1'h1;
    localparam logic RST_SOFT = 1'h1;
    localparam logic RST_LPOL = 1'h0;
    localparam logic RST_PLL = 1'h1;
    localparam logic [1:0] RST_RETRY = 2'h3;
    localparam logic RST_FACT = 1'h0;
    localparam logic [7:0] RST_THR = 8'h20;

    // ********************************
    // codes and counts
    // ********************************
    localparam logic [1:0] OTP_PROGRAM_COUNT_MAX = 2'h2;
    localparam logic [8:0] HYST_STEPS = 9'h003;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IND_TACH, IND_TACH_HALF, IND_RSVD, IND_LOCK
    } fdc_ind_sel_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } fdc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fdc_axi_rsp_t;

    typedef struct packed {
        logic [2:0] min_speed_resolution;
        logic duty_ramp_time_sel;
        logic [1:0] current_limit_sel;
        logic soft_switching_enable;
        logic phase_lock_enable;
        logic [1:0] lock_retry_time_sel;
    } fdc_cfg_t;

endpackage : fdc_pkg

// *** fdc_regs_chk.sv ***
`timescale 1ns/1ps
module fdc_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire fdc_pkg::fdc_axi_req_t axi_req,
    input wire fdc_pkg::fdc_axi_rsp_t axi_rsp,
    input wire fdc_pkg::fdc_cfg_t cfg_out,
    input wire logic ind_o,
    input wire logic nvm_otp_program_count_o
);
    // ****************
    // bus and output checks
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
    read_lat_a: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid && !axi_rsp.arready) else $error("read answer late");
    write_lat_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid) else $error("write answer late");
    write_busy_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken while busy");
    rdata_pad_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    ind_low_a: assert property (ind_o == 1'b0) else $error("indicator data driven high");
    otp_program_count_pulse_a: assert property (nvm_otp_program_count_o |=> !nvm_otp_program_count_o)
        else $error("commit pulse long");
    otp_program_count_cause_a: assert property (nvm_otp_program_count_o |-> axi_rsp.bvalid)
        else $error("commit without write");
    cfg_dflt_a: assert property (
        $fell(rst) |-> cfg_out == 10'h1ef)
        else $error("config not at defaults");
endmodule : fdc_regs_chk

bind fdc_regs fdc_regs_chk i_fdc_regs_chk (.clk(clk), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .cfg_out(cfg_out), .ind_o(ind_o), .nvm_otp_program_count_o(nvm_otp_program_count_o));

// *** fdc_regs_test.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module fdc_regs_test;
    logic clk, rst, tach, lock, test, ind_o, ind_oe_n, otp_program_count, h;
    logic [7:0] duty_in, duty_out;
    logic [7:0] wv [17];
    logic [31:0] d;
    logic [33:0] e;
    logic [1:0] eb;
    logic [3:0] stb;
    fdc_pkg::fdc_axi_req_t req;
    fdc_pkg::fdc_axi_rsp_t rsp;
    fdc_pkg::fdc_cfg_t cfg;
    logic [33:0] exp_r [$];
    logic [1:0] exp_b [$];
    int mismatches, compares, cyc, npulse;
    // last entry is an unmapped index
    logic [7:0] idx [17] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7, 8'h8, 8'h9,
        8'h0a, 8'h0b, 8'h0d, 8'h0f, 8'h10, 8'h14, 8'h0c};
    logic [7:0] dfl [17] = '{8'h1f, 8'h1f, 8'h3f, 8'h5f, 8'h7f, 8'h9f, 8'hbf, 8'hdf, 8'hff,
        8'h00, 8'h1e, 8'h20, 8'h40, 8'h70, 8'h00, 8'h20, 8'h00};
    logic [7:0] msk [17] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h00, 8'hff, 8'h20, 8'h60, 8'h70, 8'h10, 8'hff, 8'h00};
    logic [7:0] dt [8] = '{8'h30, 8'h43, 8'h44, 8'h41, 8'h30, 8'h30, 8'h40, 8'hff};
    logic [7:0] de [8] = '{8'h00, 8'h00, 8'h32, 8'h30, 8'h00, 8'h10, 8'h30, 8'h8f};

    fdc_regs i_fdc_regs (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .duty_in(duty_in), .tach_in(tach), .lock_in(lock), .test_in(test),
        .duty_out(duty_out), .cfg_out(cfg), .ind_o(ind_o), .ind_oe_n(ind_oe_n),
        .nvm_otp_program_count_o(otp_program_count));

    // ****************
    // bus tasks
    // ****************
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        @(posedge clk);
        exp_b.push_back(r);
        req.awaddr <= {a[5:0], 2'h0};
        req.wdata <= v;
        req.wstrb <= stb;
        {req.awvalid, req.wvalid, req.bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
        @(posedge clk);
        exp_r.push_back({r, 24'h0, v});
        req.araddr <= {a[5:0], 2'h0};
        {req.arvalid, req.rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        req.rready <= 1'b0;
    endtask : rd

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // ****************
    // monitor
    // ****************
    always @(posedge clk) begin
        cyc++;
        if (otp_program_count === 1'b1) npulse++;
        if (rsp.rvalid && req.rready) begin
            e = exp_r.pop_front();
            `CHK("rdata", e, {rsp.rresp, rsp.rdata})
        end
        if (rsp.bvalid && req.bready) begin
            eb = exp_b.pop_front();
            `CHK("bresp", eb, rsp.bresp)
        end
        if (cyc > 40000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        req = '0;
        {tach, lock, test, duty_in} = '0;
        stb = 4'hf;
        void'($urandom(32'hbf12c326));
        wt(16);
        rst <= 1'b0;
        for (int i = 0; i < 17; i++) begin
            rd(idx[i], dfl[i], i == 16 ? 2'h2 : 2'h0);
        end
        // random data, reserved and read-only bits must not stick
        for (int i = 0; i < 17; i++) begin
            d = $urandom;
            stb = d[31:28];
            wv[i] = (stb[0] ? d[7:0] : dfl[i]) & msk[i];
            wr(idx[i], d, i == 16 ? 2'h2 : 2'h0);
            rd(idx[i], wv[i], i == 16 ? 2'h2 : 2'h0);
        end
        stb = 4'hf;
        `CHK("cfg", {wv[10][5:0], wv[12][6], wv[13][6:4]}, cfg)
        tach <= 1'b1;
        test <= 1'b1;
        wt(4);
        rd(8'h0b, 8'hc0 | wv[11], 2'h0);
        // commit is blocked in test mode, then allowed twice only
        wr(8'h10, 32'h10, 2'h0);
        wr(8'h15, 32'h1, 2'h0);
        rd(8'h09, 8'h00, 2'h0);
        test <= 1'b0;
        wt(4);
        for (int i = 0; i < 3; i++) begin
            wr(8'h15, 32'h1, 2'h0);
            rd(8'h09, i < 2 ? 8'(i + 1) << 6 : 8'h80, 2'h0);
        end
        `CHK("pulses", 2, npulse)
        wr(8'h0a, 32'h1e, 2'h0);
        for (int t = 0; t < 2; t++) begin
            tach <= t[0];
            wt(5);
            `CHK("tach", t[0], ind_oe_n)
        end
        wr(8'h0a, 32'h5e, 2'h0);
        // new select needs one more edge to reach the pin
        wt(2);
        h = ind_oe_n;
        for (int k = 0; k < 2; k++) begin
            tach <= 1'b0;
            wt(5);
            `CHK("half", h, ind_oe_n)
            tach <= 1'b1;
            wt(5);
            `CHK("half", ~h, ind_oe_n)
            h = ~h;
        end
        wr(8'h0a, 32'hde, 2'h0);
        for (int k = 0; k < 4; k++) begin
            wr(8'h0d, {26'h0, k[1], 5'h0}, 2'h0);
            lock <= k[0];
            wt(5);
            `CHK("lock", k[0] ^ k[1], ind_oe_n)
        end
        // linear table so the blend is easy to predict
        for (int i = 0; i < 9; i++) begin
            wr(8'(i), 32'h10 + 32'(i) * 32'h10, 2'h0);
        end
        wr(8'h14, 32'h40, 2'h0);
        wr(8'h0b, 32'h20, 2'h0);
        for (int i = 0; i < 8; i++) begin
            if (i == 5) wr(8'h0b, 32'h0, 2'h0);
            duty_in <= dt[i];
            wt(3);
            `CHK("duty", de[i], duty_out)
        end
        // mid-run reset brings the settings back to defaults
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        rd(8'h14, 8'h20, 2'h0);
        rd(8'h0a, 8'h1e, 2'h0);
        wt(4);
        give_verdict();
    end
endmodule : fdc_regs_test
